// *** hdl/bpm_controller.v ***
// board power mode controller with apb register access
`timescale 1ns/1ps
`include "bpm_consts.vh"
// Function
// - seven modes, ranked off to run
// - off mode: every rail disabled
// - battery clock mode: battery rail only
// - retention: input rail, retention pins on
// - retention pins hold outputs, can wake
// - one retention pin reserved for watchdog
// - select low self-refresh, high dram off
// - retention memory rail follows select
// - low power: soc/mem on, cpu halted in deep sleep and low power idle
// - deep sleep: gate cpu, stop clocks
// - low power idle: 1MHz slow clock
// - system idle: 24MHz, cpu wfi gating
// - auto idle entry, peripherals set
// - exit latency deep, idle, system ordered
// - peripheral power on low power, run
// - run all rails; phy switchable
// - run mode core voltage scaling
module bpm_controller #(
   parameter PIN_W = 16,
   parameter PERI_W = 16,
   parameter IDLE_CNT = `BPM_IDLE_CNT
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   input wire [PIN_W-1:0] i_retention_wake_pins,
   input wire i_system_activity,
   input wire i_cpu_wait_for_interrupt_state,
   output reg o_rail_cpu_en,
   output reg o_rail_soc_en,
   output reg o_rail_dram_en,
   output reg o_rail_vin_en,
   output reg o_rail_battery_en,
   output reg o_rail_retention_io_en,
   output reg o_phy_power_en,
   output reg o_peripheral_power_enable,
   output reg o_dram_retention_select,
   output reg o_retention_pin_hold,
   output reg o_cpu_clock_gate,
   output reg o_sys_clock_stop,
   output reg o_clk_1mhz_only,
   output reg o_clk_24mhz_en,
   output reg o_voltage_frequency_scaling,
   output reg [PERI_W-1:0] o_peripheral_keep,
   output reg [2:0] o_mode,
   output wire o_irq
);
   localparam ST_IDLE = 2'b00;
   localparam ST_EXIT = 2'b01;

   reg [PIN_W-1:0] pin_s1_q;
   reg [PIN_W-1:0] pin_s2_q;
   reg [PIN_W-1:0] pin_s3_q;
   reg [PIN_W-1:0] pin_ok_q;
   wire [PIN_W-1:0] pin_chg;
   reg [PIN_W-1:0] wake_en_q;
   reg [2:0] mode_q;
   reg [2:0] target_q;
   reg [1:0] st_q;
   reg [15:0] exit_cnt_q;
   reg [15:0] idle_cnt_q;
   reg [PERI_W-1:0] peri_cfg_q;
   reg drsel_q, phy_q, auto_q, vscale_q;
   reg [`BPM_EV_W-1:0] stat_q, ien_q;
   reg [`BPM_EV_W-1:0] ev;
   reg wr_req;
   reg [2:0] req_mode;
   reg adj_ok;
   reg wake_hit;
   reg auto_hit;
   reg [15:0] exit_len;
   reg [31:0] rd_data_d;
   reg rail_cpu_d;
   reg rail_soc_d;
   reg rail_dram_d;
   reg rail_vin_d;
   reg rail_bat_d;
   reg rail_rio_d;
   reg phy_d;
   reg peri_pwr_d;
   reg pin_hold_d;
   reg cpu_gate_d;
   reg sys_stop_d;
   reg clk_slow_d;
   reg clk_fast_d;
   reg vfs_d;
   reg [PERI_W-1:0] keep_d;

   wire apb_acc = i_psel & i_penable;
   wire apb_wr = apb_acc & i_pwrite;
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   assign o_irq = |(stat_q & ien_q);

   // pin synchroniser, three stages per pin
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin_sync
         always @(posedge i_clk) begin
            if (i_rst) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
               pin_s3_q[gi] <= 1'b0;
               pin_ok_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= i_retention_wake_pins[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
               pin_s3_q[gi] <= pin_s2_q[gi];
               // accept a level once stages two and three agree
               if (pin_s2_q[gi] == pin_s3_q[gi])
                  pin_ok_q[gi] <= pin_s3_q[gi];
            end
         end
         // one-cycle pulse on an accepted change
         assign pin_chg[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) &&
                              (pin_s3_q[gi] != pin_ok_q[gi]);
      end
   endgenerate

   // transition request decode
   always @* begin
      ev = {`BPM_EV_W{1'b0}};
      wr_req = apb_wr && (i_paddr == `BPM_REG_CTRL) && i_pwdata[3];
      req_mode = i_pwdata[2:0];
      adj_ok = (req_mode <= `BPM_MODE_RUN) &&
               ((req_mode == mode_q + 3'h1) || (req_mode + 3'h1 == mode_q));
      wake_hit = (mode_q == `BPM_MODE_RET) &&
                 |(pin_chg & wake_en_q & {{(PIN_W-1){1'b1}}, 1'b0});
      auto_hit = auto_q && (mode_q == `BPM_MODE_RUN) && (idle_cnt_q == IDLE_CNT);
      case (mode_q)
         `BPM_MODE_DSL: exit_len = `BPM_EXIT_DSL;
         `BPM_MODE_LPI: exit_len = `BPM_EXIT_LPI;
         `BPM_MODE_SID: exit_len = `BPM_EXIT_SID;
         default: exit_len = 16'h0001;
      endcase
      // event pulses for the status register
      if (st_q == ST_IDLE) begin
         if (wr_req && !adj_ok)
            ev[`BPM_EV_REJ] = 1'b1;
         else if (!wr_req && wake_hit)
            ev[`BPM_EV_WAKE] = 1'b1;
         else if (!wr_req && auto_hit)
            ev[`BPM_EV_AUTO] = 1'b1;
      end else if (st_q == ST_EXIT && exit_cnt_q <= 16'h0001) begin
         ev[`BPM_EV_DONE] = 1'b1;
      end
   end

   // mode sequencer
   always @(posedge i_clk) begin
      if (i_rst) begin
         mode_q <= `BPM_MODE_OFF;
         target_q <= `BPM_MODE_OFF;
         st_q <= ST_IDLE;
         exit_cnt_q <= 16'h0000;
         idle_cnt_q <= 16'h0000;
         stat_q <= {`BPM_EV_W{1'b0}};
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (wr_req && adj_ok) begin
                  target_q <= req_mode;
                  exit_cnt_q <= (req_mode > mode_q) ? exit_len : 16'h0001;
                  st_q <= ST_EXIT;
               end else if (!wr_req && wake_hit) begin
                  target_q <= `BPM_MODE_DSL;
                  exit_cnt_q <= 16'h0001;
                  st_q <= ST_EXIT;
               end else if (!wr_req && auto_hit) begin
                  target_q <= `BPM_MODE_SID;
                  exit_cnt_q <= 16'h0001;
                  st_q <= ST_EXIT;
               end
            end
            ST_EXIT: begin
               if (exit_cnt_q <= 16'h0001) begin
                  mode_q <= target_q;
                  st_q <= ST_IDLE;
               end else begin
                  exit_cnt_q <= exit_cnt_q - 16'h0001;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         if (mode_q != `BPM_MODE_RUN || i_system_activity)
            idle_cnt_q <= 16'h0000;
         else if (idle_cnt_q != IDLE_CNT)
            idle_cnt_q <= idle_cnt_q + 16'h0001;
         // set wins over clear
         if (apb_wr && i_paddr == `BPM_REG_CLR)
            stat_q <= (stat_q & ~i_pwdata[`BPM_EV_W-1:0]) | ev;
         else
            stat_q <= stat_q | ev;
      end
   end

   // software registers
   always @(posedge i_clk) begin
      if (i_rst) begin
         drsel_q <= 1'b0;
         phy_q <= 1'b0;
         auto_q <= 1'b0;
         vscale_q <= 1'b0;
         ien_q <= {`BPM_EV_W{1'b0}};
         wake_en_q <= {PIN_W{1'b0}};
         peri_cfg_q <= {PERI_W{1'b0}};
      end else if (apb_wr) begin
         case (i_paddr)
            `BPM_REG_CTRL: begin
               drsel_q <= i_pwdata[`BPM_CTRL_DRSEL];
               phy_q <= i_pwdata[`BPM_CTRL_PHY];
               auto_q <= i_pwdata[`BPM_CTRL_AUTO];
               vscale_q <= i_pwdata[`BPM_CTRL_VSCALE];
            end
            `BPM_REG_IEN: ien_q <= i_pwdata[`BPM_EV_W-1:0];
            `BPM_REG_WAKE: wake_en_q <= i_pwdata[PIN_W-1:0];
            `BPM_REG_PERI: peri_cfg_q <= i_pwdata[PERI_W-1:0];
            default: ;
         endcase
      end
   end

   // read mux
   always @* begin
      rd_data_d = 32'h0000_0000;
      case (i_paddr)
         `BPM_REG_CTRL: rd_data_d = {24'h00_0000, vscale_q, auto_q, phy_q, drsel_q, 4'h0};
         `BPM_REG_MODE: rd_data_d = {27'h000_0000, st_q[0], 1'b0, mode_q};
         `BPM_REG_STAT: rd_data_d[`BPM_EV_W-1:0] = stat_q;
         `BPM_REG_IEN: rd_data_d[`BPM_EV_W-1:0] = ien_q;
         `BPM_REG_WAKE: rd_data_d[PIN_W-1:0] = pin_ok_q;
         `BPM_REG_PERI: rd_data_d[PERI_W-1:0] = peri_cfg_q;
         `BPM_REG_EXIT: rd_data_d[15:0] = exit_cnt_q;
         default: rd_data_d = 32'h0000_0000;
      endcase
   end

   // read data taken in setup, stands through access
   always @(posedge i_clk) begin
      if (i_rst)
         o_prdata <= 32'h0000_0000;
      else if (i_psel && !i_penable)
         o_prdata <= rd_data_d;
   end

   // rail and clock levels per mode
   always @* begin
      rail_cpu_d = 1'b0;
      rail_soc_d = 1'b0;
      rail_dram_d = 1'b0;
      rail_vin_d = 1'b0;
      rail_bat_d = 1'b0;
      rail_rio_d = 1'b0;
      peri_pwr_d = 1'b0;
      pin_hold_d = 1'b0;
      sys_stop_d = 1'b1;
      clk_slow_d = 1'b0;
      clk_fast_d = 1'b0;
      case (mode_q)
         `BPM_MODE_OFF: rail_bat_d = 1'b0;
         `BPM_MODE_BAT: rail_bat_d = 1'b1;
         `BPM_MODE_RET: begin
            rail_bat_d = 1'b1;
            rail_rio_d = 1'b1;
            rail_vin_d = 1'b1;
            pin_hold_d = 1'b1;
            rail_dram_d = !drsel_q;
         end
         `BPM_MODE_DSL: begin
            rail_bat_d = 1'b1;
            rail_rio_d = 1'b1;
            rail_vin_d = 1'b1;
            rail_soc_d = 1'b1;
            rail_dram_d = 1'b1;
            peri_pwr_d = 1'b1;
            sys_stop_d = 1'b1;
         end
         // slow clock in low power idle
         `BPM_MODE_LPI: begin
            rail_bat_d = 1'b1;
            rail_rio_d = 1'b1;
            rail_vin_d = 1'b1;
            rail_soc_d = 1'b1;
            rail_dram_d = 1'b1;
            peri_pwr_d = 1'b1;
            sys_stop_d = 1'b0;
            clk_slow_d = 1'b1;
         end
         `BPM_MODE_SID: begin
            rail_bat_d = 1'b1;
            rail_rio_d = 1'b1;
            rail_vin_d = 1'b1;
            rail_soc_d = 1'b1;
            rail_dram_d = 1'b1;
            peri_pwr_d = 1'b1;
            rail_cpu_d = 1'b1;
            sys_stop_d = 1'b0;
            clk_fast_d = 1'b1;
         end
         `BPM_MODE_RUN: begin
            rail_bat_d = 1'b1;
            rail_rio_d = 1'b1;
            rail_vin_d = 1'b1;
            rail_soc_d = 1'b1;
            rail_dram_d = 1'b1;
            peri_pwr_d = 1'b1;
            rail_cpu_d = 1'b1;
            sys_stop_d = 1'b0;
            clk_fast_d = 1'b1;
         end
         default: rail_bat_d = 1'b0;
      endcase
      phy_d = (mode_q >= `BPM_MODE_DSL) && phy_q;
      cpu_gate_d = (mode_q < `BPM_MODE_SID) ||
                   (mode_q == `BPM_MODE_SID && i_cpu_wait_for_interrupt_state);
      vfs_d = (mode_q == `BPM_MODE_RUN) && vscale_q;
      keep_d = o_peripheral_keep;
      if (st_q == ST_EXIT && exit_cnt_q <= 16'h0001 && target_q == `BPM_MODE_SID)
         keep_d = peri_cfg_q;
   end

   // rail outputs per mode
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_rail_cpu_en <= 1'b0;
         o_rail_soc_en <= 1'b0;
         o_rail_dram_en <= 1'b0;
         o_rail_vin_en <= 1'b0;
         o_rail_battery_en <= 1'b0;
         o_rail_retention_io_en <= 1'b0;
         o_phy_power_en <= 1'b0;
         o_peripheral_power_enable <= 1'b0;
         o_dram_retention_select <= 1'b0;
         o_retention_pin_hold <= 1'b0;
         o_cpu_clock_gate <= 1'b1;
         o_sys_clock_stop <= 1'b1;
         o_clk_1mhz_only <= 1'b0;
         o_clk_24mhz_en <= 1'b0;
         o_voltage_frequency_scaling <= 1'b0;
         o_peripheral_keep <= {PERI_W{1'b0}};
         o_mode <= `BPM_MODE_OFF;
      end else begin
         o_mode <= mode_q;
         o_rail_battery_en <= rail_bat_d;
         o_rail_vin_en <= rail_vin_d;
         o_rail_retention_io_en <= rail_rio_d;
         o_retention_pin_hold <= pin_hold_d;
         o_rail_soc_en <= rail_soc_d;
         o_rail_cpu_en <= rail_cpu_d;
         o_rail_dram_en <= rail_dram_d;
         o_dram_retention_select <= drsel_q;
         o_peripheral_power_enable <= peri_pwr_d;
         o_phy_power_en <= phy_d;
         o_sys_clock_stop <= sys_stop_d;
         o_clk_1mhz_only <= clk_slow_d;
         o_clk_24mhz_en <= clk_fast_d;
         o_cpu_clock_gate <= cpu_gate_d;
         o_peripheral_keep <= keep_d;
         o_voltage_frequency_scaling <= vfs_d;
      end
   end
endmodule // bpm_controller

// *** pkg/bpm_consts.vh ***
// constants for the board power mode controller
`ifndef BPM_CONSTS_VH
`define BPM_CONSTS_VH
// mode codes, lowest to highest consumption
`define BPM_MODE_OFF 3'h0
`define BPM_MODE_BAT 3'h1
`define BPM_MODE_RET 3'h2
`define BPM_MODE_DSL 3'h3
`define BPM_MODE_LPI 3'h4
`define BPM_MODE_SID 3'h5
`define BPM_MODE_RUN 3'h6
// register byte offsets
`define BPM_REG_CTRL 12'h000
`define BPM_REG_MODE 12'h004
`define BPM_REG_STAT 12'h008
`define BPM_REG_CLR 12'h00C
`define BPM_REG_IEN 12'h010
`define BPM_REG_WAKE 12'h014
`define BPM_REG_PERI 12'h018
`define BPM_REG_EXIT 12'h01C
// ctrl fields
`define BPM_CTRL_REQ_LSB 0
`define BPM_CTRL_DRSEL 4
`define BPM_CTRL_PHY 5
`define BPM_CTRL_AUTO 6
`define BPM_CTRL_VSCALE 7
// status event bits
`define BPM_EV_DONE 0
`define BPM_EV_REJ 1
`define BPM_EV_WAKE 2
`define BPM_EV_AUTO 3
`define BPM_EV_W 4
// exit latencies and auto idle count in cycles
`define BPM_EXIT_DSL 16'h0400
`define BPM_EXIT_LPI 16'h0040
`define BPM_EXIT_SID 16'h0004
`define BPM_IDLE_CNT 16'h0100
`endif

// *** tb/bpm_carrier_model.sv ***
// carrier model: wake pins and dram content
`timescale 1ns/1ps
module bpm_carrier_model (
   input wire i_clk,
   input wire i_toggle,
   input wire [3:0] i_pin,
   input wire i_fill,
   input wire i_rail_dram_en,
   output logic [15:0] o_pins = 16'h0000,
   output logic o_dram_kept = 1'b0
);
   always @(posedge i_clk) begin
      if (i_toggle) begin
         o_pins[i_pin] <= ~o_pins[i_pin];
      end
      if (!i_rail_dram_en) begin
         o_dram_kept <= 1'b0;
      end else if (i_fill) begin
         o_dram_kept <= 1'b1;
      end
   end
endmodule // bpm_carrier_model

// *** tb/bpm_controller_assertions.sv ***
// assertions on mode and rail outputs
`timescale 1ns/1ps
`include "bpm_consts.vh"
module bpm_checker (
   input wire i_clk,
   input wire i_rst,
   input wire [2:0] o_mode,
   input wire o_rail_cpu_en,
   input wire o_rail_soc_en,
   input wire o_rail_dram_en,
   input wire o_rail_vin_en,
   input wire o_rail_battery_en,
   input wire o_rail_retention_io_en,
   input wire o_phy_power_en,
   input wire o_peripheral_power_enable,
   input wire o_dram_retention_select,
   input wire o_retention_pin_hold,
   input wire o_cpu_clock_gate,
   input wire o_sys_clock_stop,
   input wire o_clk_1mhz_only,
   input wire o_clk_24mhz_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_ret_steady;
      (o_mode == `BPM_MODE_RET) [*2] ##0 $stable(o_dram_retention_select);
   endsequence
   AST_RANGE: assert property (o_mode <= `BPM_MODE_RUN)
      else $error("mode code out of range");
   AST_OFF: assert property ((o_mode == `BPM_MODE_OFF) |-> !(o_rail_cpu_en | o_rail_soc_en
      | o_rail_dram_en | o_rail_vin_en | o_rail_battery_en | o_peripheral_power_enable))
      else $error("rail on in off mode");
   AST_BAT: assert property ((o_mode == `BPM_MODE_BAT) |-> o_rail_battery_en
      && !o_rail_vin_en && !o_rail_dram_en && !o_rail_soc_en && !o_rail_cpu_en)
      else $error("battery mode rails wrong");
   AST_RET: assert property ((o_mode == `BPM_MODE_RET) |-> o_rail_vin_en
      && o_rail_retention_io_en && o_retention_pin_hold && !o_rail_soc_en
      && !o_rail_cpu_en && !o_peripheral_power_enable && !o_phy_power_en)
      else $error("retention rails wrong");
   AST_DRAM: assert property (s_ret_steady |-> o_rail_dram_en == !o_dram_retention_select)
      else $error("retention dram rail wrong");
   AST_LOW: assert property ((o_mode inside {[`BPM_MODE_DSL:`BPM_MODE_SID]})
      |-> o_rail_soc_en && o_rail_dram_en && o_peripheral_power_enable && o_rail_retention_io_en)
      else $error("low power rails wrong");
   AST_DSL: assert property ((o_mode == `BPM_MODE_DSL) |-> o_sys_clock_stop
      && o_cpu_clock_gate && !o_clk_24mhz_en)
      else $error("deep sleep clocks wrong");
   AST_LPI: assert property ((o_mode == `BPM_MODE_LPI) |-> o_clk_1mhz_only
      && o_cpu_clock_gate && !o_clk_24mhz_en)
      else $error("idle clocks wrong");
   AST_SID: assert property ((o_mode == `BPM_MODE_SID) |-> o_clk_24mhz_en && !o_sys_clock_stop)
      else $error("system idle clocks wrong");
   AST_RUN: assert property ((o_mode == `BPM_MODE_RUN) |-> o_rail_cpu_en && o_rail_vin_en
      && o_rail_dram_en && o_peripheral_power_enable && !o_cpu_clock_gate)
      else $error("run rails wrong");
   AST_ADJ: assert property (!$stable(o_mode) |->
      (o_mode == $past(o_mode) + 3'h1 || $past(o_mode) == o_mode + 3'h1))
      else $error("mode moved by more than one step");
endmodule // bpm_checker
bind bpm_controller bpm_checker i_bpm_checker (.*);

// *** tb/test_board_power_mode_controller.sv ***
// testbench for the power mode controller
`timescale 1ns/1ps
`include "bpm_consts.vh"
module test_board_power_mode_controller;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, act = 1, wait_for_interrupt_state = 0, tog = 0, fill = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd;
   logic [3:0] pin = 4'h0;
   wire [31:0] prdata;
   wire [15:0] pins, keep;
   wire [14:0] r;
   wire [2:0] mode;
   wire pready, irq, dkept, slverr;
   int fails = 0, check_count = 0, cyc = 0, t0, lat[3];
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   bpm_controller #(.IDLE_CNT(16'h0008)) i_bpm_controller (.i_clk(clk), .i_rst(rst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr), .i_retention_wake_pins(pins),
      .i_system_activity(act), .i_cpu_wait_for_interrupt_state(wait_for_interrupt_state), .o_rail_cpu_en(r[0]),
      .o_rail_soc_en(r[1]), .o_rail_dram_en(r[2]), .o_rail_vin_en(r[3]),
      .o_rail_battery_en(r[4]), .o_rail_retention_io_en(r[5]), .o_phy_power_en(r[6]),
      .o_peripheral_power_enable(r[7]), .o_dram_retention_select(r[8]),
      .o_retention_pin_hold(r[9]), .o_cpu_clock_gate(r[10]), .o_sys_clock_stop(r[11]),
      .o_clk_1mhz_only(r[12]), .o_clk_24mhz_en(r[13]), .o_voltage_frequency_scaling(r[14]),
      .o_peripheral_keep(keep), .o_mode(mode), .o_irq(irq));
   bpm_carrier_model i_bpm_carrier_model (.i_clk(clk), .i_toggle(tog), .i_pin(pin),
      .i_fill(fill), .i_rail_dram_en(r[2]), .o_pins(pins), .o_dram_kept(dkept));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      psel <= 0;
      pen <= 0;
      if (n >= 50) begin fails++; conclude(); end
      @(negedge clk);
   endtask
   task automatic step(input logic go, input logic [2:0] m, input logic [3:0] f);
      int n;
      t0 = cyc;
      if (go) apb(1, `BPM_REG_CTRL, {24'h00_0000, f, 1'b1, m});
      n = 0;
      do begin apb(0, `BPM_REG_MODE, 0); n++; end while ((rd[4] | rd[2:0] != m) && n < 900);
      if (n >= 900) begin fails++; conclude(); end
   endtask
   task automatic toggle(input logic [3:0] p);
      @(posedge clk);
      tog <= 1;
      pin <= p;
      @(posedge clk);
      tog <= 0;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      chk("off rails", 32'h0000_0C00, {17'h0_0000, r});
      apb(1, `BPM_REG_CTRL, 32'h0000_000E);
      apb(0, `BPM_REG_STAT, 0);
      chk("reject flag", 1, rd[1]);
      chk("mode kept", `BPM_MODE_OFF, mode);
      apb(1, `BPM_REG_IEN, 32'h0000_0002);
      chk("irq raised", 1, irq);
      apb(1, `BPM_REG_IEN, 32'h0000_0000);
      chk("irq masked", 0, irq);
      apb(1, `BPM_REG_CLR, 32'h0000_0002);
      apb(1, `BPM_REG_IEN, 32'h0000_0002);
      chk("irq cleared", 0, irq);
      apb(0, 12'h020, 0);
      chk("unmapped read", 0, rd);
      chk("slave error", 0, slverr);
      step(1, `BPM_MODE_BAT, 4'h0);
      chk("battery rails", 32'h0000_0C10, {17'h0_0000, r});
      step(1, `BPM_MODE_RET, 4'h0);
      chk("retention rails", 32'h0000_0E3C, {17'h0_0000, r});
      apb(1, `BPM_REG_WAKE, 32'h0000_FFFF);
      toggle(4'h0);
      repeat (12) @(posedge clk);
      chk("watchdog pin", `BPM_MODE_RET, mode);
      toggle(4'h3);
      step(0, `BPM_MODE_DSL, 4'h0);
      apb(0, `BPM_REG_STAT, 0);
      chk("wake flag", 1, rd[2]);
      step(1, `BPM_MODE_LPI, 4'h0);
      lat[0] = cyc - t0;
      step(1, `BPM_MODE_SID, 4'h0);
      lat[1] = cyc - t0;
      @(posedge clk);
      wait_for_interrupt_state <= 1;
      repeat (2) @(negedge clk);
      chk("wfi gate", 1, r[10]);
      @(posedge clk);
      wait_for_interrupt_state <= 0;
      step(1, `BPM_MODE_RUN, 4'hA);
      lat[2] = cyc - t0;
      chk("exit order", 1, lat[0] >= 1024 && lat[0] > lat[1] && lat[1] > lat[2]);
      chk("run rails", 32'h0000_60FF, {17'h0_0000, r});
      apb(1, `BPM_REG_PERI, 32'h0000_00A5);
      @(posedge clk);
      act <= 0;
      apb(1, `BPM_REG_CTRL, 32'h0000_00E6);
      step(0, `BPM_MODE_SID, 4'h0);
      @(posedge clk);
      act <= 1;
      chk("kept set", 16'h00A5, keep);
      apb(0, `BPM_REG_STAT, 0);
      chk("auto flag", 1, rd[3]);
      step(1, `BPM_MODE_LPI, 4'h0);
      step(1, `BPM_MODE_DSL, 4'h0);
      @(posedge clk);
      fill <= 1;
      @(posedge clk);
      fill <= 0;
      step(1, `BPM_MODE_RET, 4'h0);
      chk("self refresh", 1, dkept);
      step(1, `BPM_MODE_DSL, 4'h0);
      step(1, `BPM_MODE_RET, 4'h1);
      chk("dram off", 2'b10, {r[8], r[2]});
      chk("dram lost", 0, dkept);
      conclude();
   end
endmodule // test_board_power_mode_controller
